// ==== core/sct_pkg.sv ====
// Purpose: Shared constants and types for the serial control bus target.
// Assumes: 8-bit register space reached over the two-wire bus.
// Notes:   Address levels map to target addresses through one table.
package sct_pkg;

	// ----------------------------------------------------------------
	// Register space
	// ----------------------------------------------------------------
	localparam int         SCT_AW          = 8;
	localparam int         SCT_DW          = 8;
	localparam logic [7:0] SCT_OFS_ID      = 8'h00;
	localparam logic [7:0] SCT_OFS_GEN     = 8'h03;
	localparam logic [7:0] SCT_GEN_RST     = 8'hd2;
	localparam logic [7:0] SCT_ID_RST      = 8'h00;
	localparam int         SCT_ID_SRC_BIT  = 0;
	localparam int         SCT_AUTOACK_BIT = 5;

	// ----------------------------------------------------------------
	// Addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] SCT_ID_TABLE [0:7] = '{
		7'h0c, 7'h0e, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1a
	};
	// Address at which the far-side target is reached through the channel
	localparam logic [6:0] SCT_REMOTE_ALIAS = 7'h2c;

	// ----------------------------------------------------------------
	// Bit, frame and strap counts; bit phase codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SCT_BYTE_BITS   = 4'h8;
	localparam logic [4:0] SCT_FRAME_BITS  = 5'h12;
	localparam logic [1:0] SCT_STRAP_WAIT  = 2'h3;
	localparam logic [1:0] SCT_PH_LOW      = 2'h0;
	localparam logic [1:0] SCT_PH_HIGH     = 2'h1;
	localparam logic [1:0] SCT_PH_DRIVE    = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		T_IDLE, T_RX, T_ACK, T_WAIT, T_TX, T_ACKI, T_IGNORE
	} sct_tgt_e;

	typedef enum logic [2:0] {
		P_IDLE, P_HOLD, P_START, P_BIT, P_STOP
	} sct_pm_e;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} sct_job_s;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sct_rra_s;

endpackage : sct_pkg

// ==== core/sct_regmem.sv ====
// Purpose: Register storage with one port and registered read data.
// Assumes: One access per clock, chosen by the caller.
// Notes:   Array has no reset; control copies live in the caller.
`timescale 1ns/1ps
module sct_regmem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_b_in,
	// Access port
	input  wire logic          we_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [DW-1:0] wdata_in,
	output logic      [DW-1:0] rdata_out
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem[addr_in];
		end
	end

endmodule : sct_regmem

// ==== core/sct_serial_control_bus_target.sv ====
// Purpose: Two-wire control bus target with a channel proxy master.
// Assumes: Level index of the address divider arrives already digitised.
// Notes:   Core on ref_clk_in, proxy and remote access on link_clk_in.
// Overview of operation
// - One of eight addresses from select pin
// - Levels map 0x0C upward to 0x1A
// - Lines only pulled low or released
// - Stop is data rising with clock high
// - Matching address acked low, mismatch released
// - Each received write byte is acked; without auto-ack a remote write byte gets the channel's ack or nack
// - Transactions open with start, close with stop
// - Sent one seen zero: lose, release
// - After loss, wait idle, retry whole transaction
// - Local and remote register accesses arbitrated
// - Config bit picks pin or programmed address
// - Auto-ack forwards remote writes without waiting
`timescale 1ns/1ps
module sct_serial_control_bus_target
	import sct_pkg::*;
#(
	parameter int         FILT_LEN = 3,
	parameter logic [7:0] SCL_QTR  = 8'h08,
	parameter logic [7:0] IDLE_LEN = 8'h10
) (
	// Clocks and reset
	input  wire logic       ref_clk_in,
	input  wire logic       link_clk_in,
	input  wire logic       rst_b_in,
	// Address strap
	input  wire logic [2:0] address_select_pin_in,
	// Local bus pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	// Control channel pins, link domain
	input  wire logic       bidir_control_channel_scl_in,
	output logic            bidir_control_channel_scl_out,
	output logic            bidir_control_channel_scl_oe_out,
	input  wire logic       bidir_control_channel_sda_in,
	output logic            bidir_control_channel_sda_out,
	output logic            bidir_control_channel_sda_oe_out,
	// Remote register access, link domain
	input  wire logic       rra_req_in,
	input  sct_rra_s        rra_in,
	output logic            rra_busy_out,
	output logic            rra_done_out,
	output logic [7:0]      rra_rdata_out
);

	function automatic logic flt(input logic [FILT_LEN-1:0] h,
		input logic cur);
		flt = (&h) ? 1'b1 : ((~|h) ? 1'b0 : cur);
	endfunction : flt

	// ----------------------------------------------------------------
	// Pin synchronisers and deglitch filter
	// ----------------------------------------------------------------
	logic [1:0]          scl_sy, sda_sy;
	logic [FILT_LEN-1:0] scl_h, sda_h;
	logic                s_scl, s_sda, scl_d, sda_d;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			scl_h  <= '1;
			sda_h  <= '1;
			s_scl  <= 1'b1;
			s_sda  <= 1'b1;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_sy <= {scl_sy[0], scl_in};
			sda_sy <= {sda_sy[0], sda_in};
			scl_h  <= {scl_h[FILT_LEN-2:0], scl_sy[1]};
			sda_h  <= {sda_h[FILT_LEN-2:0], sda_sy[1]};
			s_scl  <= flt(scl_h, s_scl);
			s_sda  <= flt(sda_h, s_sda);
			scl_d  <= s_scl;
			sda_d  <= s_sda;
		end
	end

	wire scl_rise = s_scl & ~scl_d;
	wire scl_fall = ~s_scl & scl_d;
	wire start_ev = s_scl & scl_d & sda_d & ~s_sda;
	wire stop_ev  = s_scl & scl_d & ~sda_d & s_sda;

	// ----------------------------------------------------------------
	// Address strap, caught once after reset release
	// ----------------------------------------------------------------
	logic [2:0] sel_sy0, sel_sy1;
	logic [1:0] strap_wait;
	logic [6:0] strap_addr;
	logic [7:0] cfg_id, cfg_gen;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel_sy0    <= '0;
			sel_sy1    <= '0;
			strap_wait <= '0;
			strap_addr <= '0;
		end else begin
			sel_sy0 <= address_select_pin_in;
			sel_sy1 <= sel_sy0;
			if (strap_wait != SCT_STRAP_WAIT) begin
				strap_wait <= strap_wait + 2'h1;
				strap_addr <= SCT_ID_TABLE[sel_sy1];
			end
		end
	end

	wire [6:0] own_addr = cfg_id[SCT_ID_SRC_BIT] ? cfg_id[7:1]
		: strap_addr;
	wire       auto_ack = cfg_gen[SCT_AUTOACK_BIT];

	// ----------------------------------------------------------------
	// Crossing from the link domain
	// ----------------------------------------------------------------
	logic [2:0] rreq_sy, pdone_sy;
	logic       rreq_tgl, pdone_tgl, pres_ok;
	sct_rra_s   rra_hold;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rreq_sy  <= '0;
			pdone_sy <= '0;
		end else begin
			rreq_sy  <= {rreq_sy[1:0], rreq_tgl};
			pdone_sy <= {pdone_sy[1:0], pdone_tgl};
		end
	end

	wire rreq_ev  = rreq_sy[2] ^ rreq_sy[1];
	wire pdone_ev = pdone_sy[2] ^ pdone_sy[1];

	// ----------------------------------------------------------------
	// Register port arbiter, round robin between local and remote
	// ----------------------------------------------------------------
	logic       loc_pend, loc_we, rem_pend, last_rem;
	logic [7:0] loc_addr, loc_wdata, rd_byte, rra_q;
	logic       g_loc_q, g_rem_q, sel_id_q, sel_gen_q;
	logic       rack_tgl;
	logic [7:0] mem_q;

	wire       g_loc   = loc_pend & (~rem_pend | last_rem);
	wire       g_rem   = rem_pend & ~g_loc;
	wire [7:0] m_addr  = g_loc ? loc_addr : rra_hold.addr;
	wire [7:0] m_wdata = g_loc ? loc_wdata : rra_hold.wdata;
	wire       m_we    = (g_loc & loc_we) | (g_rem & rra_hold.we);
	wire [7:0] rd_mux  = sel_id_q ? {own_addr, cfg_id[SCT_ID_SRC_BIT]}
		: (sel_gen_q ? cfg_gen : mem_q);

	sct_regmem #(
		.AW (SCT_AW),
		.DW (SCT_DW)
	) u_mem (
		.clk_in    (ref_clk_in),
		.rst_b_in  (rst_b_in),
		.we_in     (m_we),
		.addr_in   (m_addr),
		.wdata_in  (m_wdata),
		.rdata_out (mem_q)
	);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rem_pend  <= 1'b0;
			last_rem  <= 1'b0;
			g_loc_q   <= 1'b0;
			g_rem_q   <= 1'b0;
			sel_id_q  <= 1'b0;
			sel_gen_q <= 1'b0;
			cfg_id    <= SCT_ID_RST;
			cfg_gen   <= SCT_GEN_RST;
			rd_byte   <= '0;
			rra_q     <= '0;
			rack_tgl  <= 1'b0;
		end else begin
			// New request wins over the grant that clears the old one
			rem_pend  <= rreq_ev | (rem_pend & ~g_rem);
			if (g_loc | g_rem) begin
				last_rem <= g_rem;
			end
			g_loc_q   <= g_loc;
			g_rem_q   <= g_rem;
			sel_id_q  <= (m_addr == SCT_OFS_ID);
			sel_gen_q <= (m_addr == SCT_OFS_GEN);
			if (m_we && m_addr == SCT_OFS_ID) begin
				cfg_id <= m_wdata;
			end
			if (m_we && m_addr == SCT_OFS_GEN) begin
				cfg_gen <= m_wdata;
			end
			if (g_loc_q) begin
				rd_byte <= rd_mux;
			end
			if (g_rem_q) begin
				rra_q    <= rd_mux;
				rack_tgl <= ~rack_tgl;
			end
		end
	end

	// ----------------------------------------------------------------
	// Target state machine
	// ----------------------------------------------------------------
	sct_tgt_e   state;
	logic [3:0] cnt;
	logic [7:0] shreg, txd, offset;
	logic       is_addr, rw, remote, first, sda_low, scl_low, job_tgl;
	sct_job_s   job;

	wire addr_hit  = (shreg[7:1] == own_addr);
	wire alias_hit = (shreg[7:1] == SCT_REMOTE_ALIAS) & ~shreg[0];
	wire byte_end  = scl_fall & (cnt == SCT_BYTE_BITS);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state     <= T_IDLE;
			cnt       <= '0;
			shreg     <= '0;
			txd       <= '0;
			offset    <= '0;
			is_addr   <= 1'b0;
			rw        <= 1'b0;
			remote    <= 1'b0;
			first     <= 1'b0;
			sda_low   <= 1'b0;
			scl_low   <= 1'b0;
			job_tgl   <= 1'b0;
			job       <= '0;
			loc_pend  <= 1'b0;
			loc_we    <= 1'b0;
			loc_addr  <= '0;
			loc_wdata <= '0;
		end else begin
			if (g_loc) begin
				loc_pend <= 1'b0;
			end
			if (start_ev) begin
				state   <= T_RX;
				cnt     <= '0;
				is_addr <= 1'b1;
				sda_low <= 1'b0;
				scl_low <= 1'b0;
			end else if (stop_ev) begin
				state   <= T_IDLE;
				sda_low <= 1'b0;
				scl_low <= 1'b0;
			end else begin
				unique case (state)
					T_IDLE, T_IGNORE: begin
					end
					T_RX: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], s_sda};
							cnt   <= cnt + 4'h1;
						end else if (byte_end) begin
							cnt <= '0;
							if (is_addr) begin
								is_addr <= 1'b0;
								first   <= 1'b1;
								rw      <= shreg[0];
								remote  <= ~addr_hit;
								if (addr_hit || alias_hit) begin
									state   <= T_ACK;
									sda_low <= 1'b1;
									if (addr_hit && shreg[0]) begin
										loc_pend <= 1'b1;
										loc_we   <= 1'b0;
										loc_addr <= offset;
										offset   <= offset + 8'h01;
									end
								end else begin
									state <= T_IGNORE;
								end
							end else if (remote) begin
								job     <= '{addr: SCT_REMOTE_ALIAS,
									data: shreg};
								job_tgl <= ~job_tgl;
								if (auto_ack) begin
									state   <= T_ACK;
									sda_low <= 1'b1;
								end else begin
									state   <= T_WAIT;  // Stretch clock
									scl_low <= 1'b1;
								end
							end else begin
								state   <= T_ACK;
								sda_low <= 1'b1;
								first   <= 1'b0;
								if (first) begin
									offset <= shreg;
								end else begin
									loc_pend  <= 1'b1;
									loc_we    <= 1'b1;
									loc_addr  <= offset;
									loc_wdata <= shreg;
									offset    <= offset + 8'h01;
								end
							end
						end
					end
					T_WAIT: begin
						// Clock freed one cycle later so data sets up first
						if (pdone_ev) begin
							state   <= T_ACK;
							sda_low <= pres_ok;
						end
					end
					T_ACK: begin
						scl_low <= 1'b0;
						if (scl_fall) begin
							cnt <= '0;
							if (rw) begin
								state   <= T_TX;
								txd     <= rd_byte;
								sda_low <= ~rd_byte[7];
							end else begin
								state   <= T_RX;
								sda_low <= 1'b0;
							end
						end
					end
					T_TX: begin
						if (scl_rise) begin
							cnt <= cnt + 4'h1;
						end else if (byte_end) begin
							state   <= T_ACKI;
							sda_low <= 1'b0;
							cnt     <= '0;
						end else if (scl_fall) begin
							sda_low <= ~txd[6];
							txd     <= {txd[6:0], 1'b0};
						end
					end
					T_ACKI: begin
						if (scl_rise && s_sda) begin
							state <= T_IGNORE;
						end else if (scl_rise) begin
							loc_pend <= 1'b1;
							loc_we   <= 1'b0;
							loc_addr <= offset;
							offset   <= offset + 8'h01;
						end else if (scl_fall) begin
							state   <= T_TX;
							txd     <= rd_byte;
							sda_low <= ~rd_byte[7];
						end
					end
				endcase
			end
		end
	end

	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = scl_low;
	assign sda_oe_out = sda_low;

	// ----------------------------------------------------------------
	// Link domain: reset release, synchronisers, remote access
	// ----------------------------------------------------------------
	logic [1:0] lrst_sy;
	logic [2:0] job_sy, rack_sy;
	logic [1:0] bscl_sy, bsda_sy;

	wire lrst_b = lrst_sy[1];

	always_ff @(posedge link_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lrst_sy <= '0;
		end else begin
			lrst_sy <= {lrst_sy[0], 1'b1};
		end
	end

	always_ff @(posedge link_clk_in or negedge lrst_b) begin
		if (!lrst_b) begin
			job_sy        <= '0;
			rack_sy       <= '0;
			bscl_sy       <= 2'h3;
			bsda_sy       <= 2'h3;
			rreq_tgl      <= 1'b0;
			rra_hold      <= '0;
			rra_busy_out  <= 1'b0;
			rra_done_out  <= 1'b0;
			rra_rdata_out <= '0;
		end else begin
			job_sy       <= {job_sy[1:0], job_tgl};
			rack_sy      <= {rack_sy[1:0], rack_tgl};
			bscl_sy      <= {bscl_sy[0], bidir_control_channel_scl_in};
			bsda_sy      <= {bsda_sy[0], bidir_control_channel_sda_in};
			rra_done_out <= rack_sy[2] ^ rack_sy[1];
			if (rack_sy[2] ^ rack_sy[1]) begin
				rra_busy_out  <= 1'b0;
				rra_rdata_out <= rra_q;
			end else if (rra_req_in && !rra_busy_out) begin
				rra_hold     <= rra_in;
				rreq_tgl     <= ~rreq_tgl;
				rra_busy_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Proxy master on the control channel
	// ----------------------------------------------------------------
	sct_pm_e     pm_state;
	logic [1:0]  ph;
	logic [7:0]  qcnt, idle_cnt;
	logic [4:0]  bitn;
	logic [17:0] frame, ackm;
	logic        nack, m_scl_low, m_sda_low;

	wire b_scl = bscl_sy[1];
	wire b_sda = bsda_sy[1];
	// Counter frozen while a target holds the clock low in the P_BIT high phase
	wire q_run = ~(pm_state == P_BIT && ph == SCT_PH_HIGH && !b_scl);
	wire tick  = q_run & (qcnt == SCL_QTR - 8'h01);
	wire lost  = ~ackm[17] & frame[17] & ~b_sda;

	always_ff @(posedge link_clk_in or negedge lrst_b) begin
		if (!lrst_b) begin
			pm_state  <= P_IDLE;
			ph        <= SCT_PH_LOW;
			qcnt      <= '0;
			idle_cnt  <= '0;
			bitn      <= '0;
			frame     <= '0;
			ackm      <= '0;
			nack      <= 1'b0;
			m_scl_low <= 1'b0;
			m_sda_low <= 1'b0;
			pdone_tgl <= 1'b0;
			pres_ok   <= 1'b0;
		end else begin
			qcnt <= (tick || !q_run) ? qcnt : qcnt + 8'h01;
			if (tick) begin
				qcnt <= '0;
			end
			unique case (pm_state)
				P_IDLE: begin
					if (job_sy[2] ^ job_sy[1]) begin
						pm_state <= P_HOLD;
						idle_cnt <= '0;
					end
				end
				P_HOLD: begin
					idle_cnt <= (b_scl & b_sda) ? idle_cnt + 8'h01 : '0;
					if (idle_cnt == IDLE_LEN) begin
						pm_state  <= P_START;
						frame     <= {job.addr, 1'b0, 1'b1, job.data, 1'b1};
						ackm      <= 18'h00201;  // Slots after R/W and data
						bitn      <= '0;
						nack      <= 1'b0;
						ph        <= SCT_PH_LOW;
						qcnt      <= '0;
						m_sda_low <= 1'b1;
					end
				end
				P_START: begin
					if (tick) begin
						m_scl_low <= 1'b1;
						pm_state  <= P_BIT;
						ph        <= SCT_PH_DRIVE;
					end
				end
				P_BIT: begin
					if (tick && ph == SCT_PH_LOW) begin
						m_scl_low <= 1'b0;
						ph        <= SCT_PH_HIGH;
					end else if (tick && ph == SCT_PH_HIGH && lost) begin
						m_sda_low <= 1'b0;
						m_scl_low <= 1'b0;
						pm_state  <= P_HOLD;
						idle_cnt  <= '0;
					end else if (tick && ph == SCT_PH_HIGH) begin
						nack      <= nack | (ackm[17] & b_sda);
						m_scl_low <= 1'b1;
						frame     <= {frame[16:0], 1'b0};
						ackm      <= {ackm[16:0], 1'b0};
						bitn      <= bitn + 5'h01;
						ph        <= SCT_PH_DRIVE;
					end else if (tick && bitn == SCT_FRAME_BITS) begin
						m_sda_low <= 1'b1;
						pm_state  <= P_STOP;
						ph        <= SCT_PH_LOW;
					end else if (tick) begin
						m_sda_low <= ~frame[17];
						ph        <= SCT_PH_LOW;
					end
				end
				P_STOP: begin
					if (tick && ph == SCT_PH_LOW) begin
						m_scl_low <= 1'b0;
						ph        <= SCT_PH_HIGH;
					end else if (tick) begin
						m_sda_low <= 1'b0;
						pres_ok   <= ~nack;
						pdone_tgl <= ~pdone_tgl;
						pm_state  <= P_IDLE;
					end
				end
			endcase
		end
	end

	assign bidir_control_channel_scl_out    = 1'b0;
	assign bidir_control_channel_sda_out    = 1'b0;
	assign bidir_control_channel_scl_oe_out = m_scl_low;
	assign bidir_control_channel_sda_oe_out = m_sda_low;

endmodule : sct_serial_control_bus_target

// ==== tb/sct_props.sv ====
// Purpose: Port checks for the serial control bus target.
// Assumes: Line inputs carry the resolved wire levels.
// Notes:   Remote port and channel checks run on link_clk_in.
`timescale 1ns/1ps
module sct_props
	import sct_pkg::*;
#(
	parameter logic [7:0] IDLE_LEN = 8'h10
) (
	// Clocks, reset, strap
	input wire logic       ref_clk_in,
	input wire logic       link_clk_in,
	input wire logic       rst_b_in,
	input wire logic [2:0] address_select_pin_in,
	// Local bus
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe_out,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	// Channel and remote port
	input wire logic       bidir_control_channel_scl_in,
	input wire logic       bidir_control_channel_scl_out,
	input wire logic       bidir_control_channel_scl_oe_out,
	input wire logic       bidir_control_channel_sda_in,
	input wire logic       bidir_control_channel_sda_out,
	input wire logic       bidir_control_channel_sda_oe_out,
	input wire logic       rra_req_in,
	input wire sct_rra_s   rra_in,
	input wire logic       rra_busy_out,
	input wire logic       rra_done_out,
	input wire logic [7:0] rra_rdata_out
);
	wire        ch_scl = bidir_control_channel_scl_in;
	wire        ch_sda = bidir_control_channel_sda_in;
	logic [7:0] idle_cnt;
	logic [7:0] next_idle_cnt;
	// Raw lines run ahead of the design's synchroniser, so this over-counts
	assign next_idle_cnt = !(ch_scl && ch_sda) ? 8'h00 :
		(idle_cnt == 8'hff) ? idle_cnt : idle_cnt + 8'h01;
	always_ff @(posedge link_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			idle_cnt <= 8'h00;
		else
			idle_cnt <= next_idle_cnt;
	end
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence
	sequence s_take;
		rra_req_in && !rra_busy_out;
	endsequence
	property p_local_low;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!scl_out && !sda_out;
	endproperty
	a_local_low: assert property (p_local_low)
		else $error("local line driven high");
	property p_chan_low;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		!bidir_control_channel_scl_out && !bidir_control_channel_sda_out;
	endproperty
	a_chan_low: assert property (p_chan_low)
		else $error("channel line driven high");
	property p_drive_low;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$rose(sda_oe_out) |-> !scl_in;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("data pulled while clock high");
	property p_stop_quiet;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		s_stop |=> (!sda_oe_out && !scl_oe_out) [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("target drives after stop");
	property p_take;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		s_take |=> rra_busy_out;
	endproperty
	a_take: assert property (p_take)
		else $error("remote request not taken");
	property p_answer;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		$rose(rra_busy_out) |-> ##[1:40] rra_done_out;
	endproperty
	a_answer: assert property (p_answer)
		else $error("remote access never completes");
	property p_done_pulse;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		rra_done_out |-> !rra_busy_out ##1 !rra_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done not a single pulse");
	property p_rdata_hold;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		$changed(rra_rdata_out) |-> rra_done_out;
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without done");
	property p_chan_start;
		@(posedge link_clk_in) disable iff (!rst_b_in)
		$rose(bidir_control_channel_sda_oe_out) && ch_scl |->
			idle_cnt >= IDLE_LEN;
	endproperty
	a_chan_start: assert property (p_chan_start)
		else $error("channel start on a busy bus");
endmodule : sct_props
bind sct_serial_control_bus_target sct_props #(.IDLE_LEN(IDLE_LEN))
	u_sct_props (.*);

// ==== tb/sct_host_bfm.sv ====
// Purpose: Host controller model mastering the two-wire bus.
// Assumes: The bench resolves wired-and levels.
// Notes:   Each bit phase lasts QTR core clocks.
`timescale 1ns/1ps
module sct_host_bfm #(
	parameter int QTR = 16
) (
	input  wire logic clk_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_oe_out,
	output logic      sda_oe_out,
	output logic      hung_out
);
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
		hung_out = 1'b0;
	end
	task automatic qwait();
		repeat (QTR) @(posedge clk_in);
	endtask : qwait
	// Bounded, so a stuck target ends the run
	task automatic scl_up();
		int n;
		scl_oe_out <= 1'b0;
		n = 0;
		@(posedge clk_in);
		while (!scl_in && n < 20000) begin
			@(posedge clk_in);
			n++;
		end
		hung_out <= !scl_in;
		qwait();
	endtask : scl_up
	task automatic bit_io(input logic b, output logic r);
		sda_oe_out <= !b;
		qwait();
		scl_up();
		r = sda_in;
		scl_oe_out <= 1'b1;
		qwait();
	endtask : bit_io
	task automatic byte_io(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack_out);
	endtask : byte_io
	task automatic start();
		sda_oe_out <= 1'b1;
		qwait();
		scl_oe_out <= 1'b1;
		qwait();
	endtask : start
	task automatic restart();
		sda_oe_out <= 1'b0;
		qwait();
		scl_up();
		start();
	endtask : restart
	task automatic stop();
		sda_oe_out <= 1'b1;
		qwait();
		scl_up();
		sda_oe_out <= 1'b0;
		qwait();
	endtask : stop
endmodule : sct_host_bfm

// ==== tb/sct_serial_control_bus_target_tb.sv ====
// Purpose: Self-checking bench for the serial control bus target.
// Assumes: Pull-ups on every line; nothing answers on the channel.
// Notes:   Channel timing shortened through parameters.
`timescale 1ns/1ps
module sct_serial_control_bus_target_tb;
	import sct_pkg::*;
	localparam logic [6:0] ME = 7'h1a;
	logic       ref_clk_in = 1'b0;
	logic       link_clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic [2:0] address_select_pin_in = 3'h0;
	logic       rra_req_in = 1'b0;
	sct_rra_s   rra_in = '0;
	logic       scl_out, scl_oe_out, sda_out, sda_oe_out, m_scl, m_sda, hung;
	logic       ch_scl_out, ch_scl_oe, ch_sda_out, ch_sda_oe;
	logic       rra_busy_out, rra_done_out;
	logic [7:0] rra_rdata_out, d;
	wire        scl_in = !(scl_oe_out || m_scl);
	wire        sda_in = !(sda_oe_out || m_sda);
	int         errors = 0;
	int         tests_run = 0;
	always #2.5 ref_clk_in = ~ref_clk_in;
	always #16 link_clk_in = ~link_clk_in;
	sct_serial_control_bus_target #(.SCL_QTR(8'h02), .IDLE_LEN(8'h04))
	u_sct_serial_control_bus_target (.ref_clk_in, .link_clk_in, .rst_b_in,
		.address_select_pin_in, .scl_in, .scl_out, .scl_oe_out, .sda_in,
		.sda_out, .sda_oe_out, .bidir_control_channel_scl_in(!ch_scl_oe),
		.bidir_control_channel_scl_out(ch_scl_out),
		.bidir_control_channel_scl_oe_out(ch_scl_oe),
		.bidir_control_channel_sda_in(!ch_sda_oe),
		.bidir_control_channel_sda_out(ch_sda_out),
		.bidir_control_channel_sda_oe_out(ch_sda_oe), .rra_req_in, .rra_in,
		.rra_busy_out, .rra_done_out, .rra_rdata_out);
	sct_host_bfm u_sct_host_bfm (.clk_in(ref_clk_in), .scl_in, .sda_in,
		.scl_oe_out(m_scl), .sda_oe_out(m_sda), .hung_out(hung));
	task automatic end_sim();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	always @(posedge hung) begin
		errors++;
		end_sim();
	end
	task automatic chk_ack(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected ack at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_ack
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected data at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic wbyte(input logic [7:0] b, input logic exp);
		logic [7:0] rx;
		logic       a;
		u_sct_host_bfm.byte_io(b, 1'b1, rx, a);
		chk_ack(a, exp);
	endtask : wbyte
	task automatic rd_local(input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] rx;
		logic       a;
		wbyte(off, 1'b0);
		u_sct_host_bfm.restart();
		wbyte({ME, 1'b1}, 1'b0);
		u_sct_host_bfm.byte_io(8'hff, 1'b1, rx, a);
		chk_byte(rx, exp);
		u_sct_host_bfm.stop();
	endtask : rd_local
	task automatic do_reset(input logic [2:0] s);
		address_select_pin_in <= s;
		rst_b_in <= 1'b0;
		repeat (12) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		repeat (20) @(posedge ref_clk_in);
	endtask : do_reset
	task automatic rra(input logic we, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		@(posedge link_clk_in);
		rra_req_in <= 1'b1;
		rra_in <= '{we: we, addr: a, wdata: wd};
		@(posedge link_clk_in);
		rra_req_in <= 1'b0;
		n = 0;
		@(negedge link_clk_in);
		while (!rra_done_out && n < 100) begin
			@(negedge link_clk_in);
			n++;
		end
		if (rra_done_out !== 1'b1) begin
			errors++;
			end_sim();
		end
		rd = rra_rdata_out;
	endtask : rra
	task automatic opn(input logic [6:0] a, input logic exp);
		u_sct_host_bfm.start();
		wbyte({a, 1'b0}, exp);
	endtask : opn
	task automatic t_addr();
		logic [6:0] own;
		for (int i = 0; i < 8; i++) begin
			own = 7'(8'h0c + 2 * i);
			do_reset(3'(i));
			opn(own, 1'b0);
			u_sct_host_bfm.stop();
			opn(7'(own + 7'h01), 1'b1);
			u_sct_host_bfm.stop();
		end
	endtask : t_addr
	task automatic t_wr_rd();
		opn(ME, 1'b0);
		wbyte(8'h18, 1'b0);
		wbyte(8'ha5, 1'b0);
		wbyte(8'h5a, 1'b0);
		u_sct_host_bfm.restart();
		wbyte({ME, 1'b0}, 1'b0);
		rd_local(8'h19, 8'h5a);
	endtask : t_wr_rd
	task automatic t_id();
		opn(ME, 1'b0);
		rd_local(8'h00, {ME, 1'b0});
		opn(ME, 1'b0);
		wbyte(8'h00, 1'b0);
		wbyte({7'h33, 1'b1}, 1'b0);
		u_sct_host_bfm.stop();
		opn(7'h33, 1'b0);
		u_sct_host_bfm.stop();
		opn(ME, 1'b1);
		u_sct_host_bfm.stop();
		do_reset(3'h7);
	endtask : t_id
	task automatic t_rra();
		fork
			begin
				opn(ME, 1'b0);
				wbyte(8'h18, 1'b0);
				wbyte(8'h77, 1'b0);
				u_sct_host_bfm.stop();
			end
			for (int k = 0; k < 6; k++)
				rra(1'b1, 8'h19, 8'(8'h91 + k), d);
		join
		rra(1'b0, 8'h18, 8'h00, d);
		chk_byte(d, 8'h77);
		opn(ME, 1'b0);
		rd_local(8'h19, 8'h96);
	endtask : t_rra
	task automatic t_alias();
		opn(SCT_REMOTE_ALIAS, 1'b0);
		wbyte(8'h5e, 1'b1);
		u_sct_host_bfm.stop();
		opn(ME, 1'b0);
		wbyte(8'h03, 1'b0);
		wbyte(8'hf2, 1'b0);
		u_sct_host_bfm.stop();
		opn(SCT_REMOTE_ALIAS, 1'b0);
		wbyte(8'h5e, 1'b0);
		u_sct_host_bfm.stop();
	endtask : t_alias
	initial begin
		do_reset(3'h0);
		t_addr();
		t_wr_rd();
		t_id();
		t_rra();
		t_alias();
		end_sim();
	end
endmodule : sct_serial_control_bus_target_tb
